// file: shared/xwf_map.vh
// Constants for the exclusive-OR working-register-with-file instruction unit.
`ifndef XWF_MAP_VH
`define XWF_MAP_VH
`define XWF_OPC_MSB        15
`define XWF_OPC_LSB        10
`define XWF_OPC_VAL        6'h06
`define XWF_DEST_BIT       9
`define XWF_ACC_BIT        8
`define XWF_ADDR_MSB       7
`define XWF_ADDR_LSB       0
`define XWF_IDX_LIMIT      8'h5F
`define XWF_ACC_HI_BANK    4'hF
`define XWF_ACC_HI_BASE    8'h60
`define XWF_NEG_BIT        7
`define XWF_W_RESET        8'h00
`define XWF_ADDR_RESET     12'h000
`define XWF_BYTE_RESET     8'h00
`define XWF_ZERO_BYTE      8'h00
`define XWF_BSR_RESET      4'h0
`define XWF_STATUS_RESET   5'h00
`define XWF_ST_Z           2
`define XWF_ST_N           4
`define XWF_PH_Q1          2'h0
`define XWF_PH_Q2          2'h1
`define XWF_PH_Q3          2'h2
`define XWF_PH_Q4          2'h3
`endif

// file: logic/xwf_phase.v
// Quarter-phase sequencer that divides the core clock into instruction cycles.
`timescale 1ns/1ps
`default_nettype none
`include "xwf_map.vh"
module xwf_phase (
    input  wire       mclk,    // Core clock.
    input  wire       rst,     // Synchronous reset, active high.
    output reg  [1:0] phase_q  // Current quarter phase.
);
    always @(posedge mclk) begin
        if (rst) begin
            phase_q <= `XWF_PH_Q1;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end
endmodule // xwf_phase
`default_nettype wire

// file: logic/xwf_core.v
// Execution unit for the exclusive-OR of the working register with a file register.
`timescale 1ns/1ps
`default_nettype none
`include "xwf_map.vh"
// Summary of operation
// [RULE1] Result is working register XOR selected file register, sent to chosen destination.
// [RULE2] Decoded from one 16-bit word: 000110, dest bit, access bit, 8-bit address.
// [RULE3] Destination 0 writes working register; destination 1 writes back to file.
// [RULE4] Access 0 uses access bank; access 1 uses bank select register bank.
// [RULE5] Extended set, access 0, address up to 95: indexed literal offset addressing.
// [RULE6] Only negative and zero flags change; other status flags keep value.
// [RULE7] One program word, one instruction cycle, no stall.
// [RULE8] Decode in Q1, read file in Q2, compute in Q3, write destination in Q4.
// [RULE9] Negative takes result bit 7; zero set when all result bits are zero.
module xwf_core (
    input  wire        mclk,          // Core clock, 40 MHz.
    input  wire        rst,           // Synchronous reset, active high.
    input  wire [15:0] instr,         // Instruction word, held for the whole cycle.
    input  wire        ext_en,        // Extended instruction set enable.
    input  wire [3:0]  bsr_in,        // Bank select register value.
    input  wire [11:0] index_base,    // Index register base for literal offset mode.
    input  wire [7:0]  mem_rdata,     // File register read data, valid in Q2.
    input  wire [4:0]  status_in,     // Current status flags.
    output reg  [11:0] mem_addr,      // File register address.
    output reg         mem_rd,        // File read strobe in Q2.
    output reg         mem_we,        // File write strobe, high for the cycle after the Q4 edge.
    output reg  [7:0]  mem_wdata,     // File write data.
    output reg  [7:0]  wreg_q,        // Working register.
    output reg  [4:0]  status_q,      // Status flags after execution.
    output reg         done_q         // One-cycle pulse when an instruction retires.
);
    wire [1:0]  phase;
    reg         hit_q;
    reg         dest_q;
    reg  [7:0]  opnd_q;
    reg  [7:0]  res_q;

    xwf_phase u_phase (
        .mclk    (mclk),
        .rst     (rst),
        .phase_q (phase)
    );

    function is_xwf;
        input [15:0] w;
        begin
            is_xwf = (w[`XWF_OPC_MSB:`XWF_OPC_LSB] == `XWF_OPC_VAL); // [RULE2]
        end
    endfunction

    function [11:0] eff_addr;
        input [15:0] w;
        input        ext;
        input [3:0]  bank;
        input [11:0] base;
        reg   [7:0]  f;
        begin
            f = w[`XWF_ADDR_MSB:`XWF_ADDR_LSB];
            if (w[`XWF_ACC_BIT]) begin
                eff_addr = {bank, f}; // [RULE4]
            end else if (ext && (f <= `XWF_IDX_LIMIT)) begin
                eff_addr = base + {4'h0, f}; // [RULE5]
            end else if (f >= `XWF_ACC_HI_BASE) begin
                eff_addr = {`XWF_ACC_HI_BANK, f}; // [RULE4]
            end else begin
                eff_addr = {4'h0, f}; // [RULE4]
            end
        end
    endfunction

    // Every step is tied to a fixed phase so the instruction never stalls.
    // Each quarter phase has a named code; the sequencer walks them in order.
    localparam [1:0] PH_DECODE  = `XWF_PH_Q1;
    localparam [1:0] PH_READ    = `XWF_PH_Q2;
    localparam [1:0] PH_PROCESS = `XWF_PH_Q3;
    localparam [1:0] PH_WRITE   = `XWF_PH_Q4;

    wire        q1_now;
    wire        q2_now;
    wire        q3_now;
    wire        q4_now;
    wire        hit_d;
    wire        dest_d;
    wire [11:0] addr_d;
    wire [7:0]  res_d;
    wire [4:0]  flags_d;
    reg  [7:0]  wreg_d;
    reg  [4:0]  status_d;
    reg         we_d;

    // Merges the new negative and zero flags into the untouched status bits.
    function [4:0] flag_merge;
        input [4:0] old;
        input [7:0] r;
        begin
            flag_merge = old; // [RULE6]
            flag_merge[`XWF_ST_N] = r[`XWF_NEG_BIT]; // [RULE9]
            flag_merge[`XWF_ST_Z] = (r == `XWF_ZERO_BYTE); // [RULE9]
        end
    endfunction

    assign q1_now = (phase == PH_DECODE);
    assign q2_now = (phase == PH_READ);
    assign q3_now = (phase == PH_PROCESS);
    assign q4_now = (phase == PH_WRITE);

    // Fields are decoded combinationally and registered only at the Q1 edge.
    assign hit_d   = is_xwf(instr); // [RULE2]
    assign dest_d  = instr[`XWF_DEST_BIT]; // [RULE3]
    assign addr_d  = eff_addr(instr, ext_en, bsr_in, index_base); // [RULE4] [RULE5]
    assign res_d   = wreg_q ^ opnd_q; // [RULE1]
    assign flags_d = flag_merge(status_in, res_q); // [RULE6] [RULE9]

    // Next values of the retiring state, worked out in one place for Q4.
    // Status is copied at every Q4 edge, so a non-matching word passes flags through.
    always @* begin
        wreg_d   = wreg_q;
        status_d = status_q;
        we_d     = 1'b0;
        if (q4_now) begin
            status_d = status_in; // [RULE6]
            if (hit_q) begin
                status_d = flags_d; // [RULE6] [RULE9]
                if (dest_q) begin
                    we_d = 1'b1; // [RULE3]
                end else begin
                    wreg_d = res_q; // [RULE3]
                end
            end
        end
    end

    // Decode stage: the word only has to stand until the Q1 edge.
    always @(posedge mclk) begin
        if (rst) begin
            hit_q  <= 1'b0;
            dest_q <= 1'b0;
        end else if (q1_now) begin
            hit_q  <= hit_d; // [RULE8]
            dest_q <= dest_d;
        end
    end

    // The address is registered in Q1 so it stays steady through the read in Q2.
    always @(posedge mclk) begin
        if (rst) begin
            mem_addr <= `XWF_ADDR_RESET;
        end else if (q1_now) begin
            mem_addr <= addr_d; // [RULE4] [RULE5]
        end
    end

    // The read strobe is a single-cycle pulse covering Q2 only.
    always @(posedge mclk) begin
        if (rst) begin
            mem_rd <= 1'b0;
        end else begin
            mem_rd <= q1_now & hit_d; // [RULE8]
        end
    end

    // Operand is taken at the Q2 edge; the memory may change its data afterwards.
    always @(posedge mclk) begin
        if (rst) begin
            opnd_q <= `XWF_BYTE_RESET;
        end else if (q2_now) begin
            opnd_q <= mem_rdata; // [RULE8]
        end
    end

    // Result is formed in Q3 from the working register as it stands in this cycle.
    always @(posedge mclk) begin
        if (rst) begin
            res_q <= `XWF_BYTE_RESET;
        end else if (q3_now) begin
            res_q <= res_d; // [RULE1] [RULE8]
        end
    end

    // A write-back raises the strobe for one cycle after the Q4 edge.
    always @(posedge mclk) begin
        if (rst) begin
            mem_we <= 1'b0;
        end else begin
            mem_we <= we_d; // [RULE3] [RULE8]
        end
    end

    // Write data changes only with the strobe, so memory never sees a stray value.
    always @(posedge mclk) begin
        if (rst) begin
            mem_wdata <= `XWF_BYTE_RESET;
        end else if (we_d) begin
            mem_wdata <= res_q; // [RULE1]
        end
    end

    // The working register is only touched when the destination bit is clear.
    always @(posedge mclk) begin
        if (rst) begin
            wreg_q <= `XWF_W_RESET;
        end else begin
            wreg_q <= wreg_d; // [RULE3]
        end
    end

    // Flags are owned by the core; this unit only hands back the merged value.
    always @(posedge mclk) begin
        if (rst) begin
            status_q <= `XWF_STATUS_RESET;
        end else begin
            status_q <= status_d; // [RULE6]
        end
    end

    // Retire pulse: set at the Q4 edge, fixed three edges after decode, never stretched by a stall.
    always @(posedge mclk) begin
        if (rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= q4_now & hit_q; // [RULE7]
        end
    end
endmodule // xwf_core
`default_nettype wire

// file: tb/xwf_core_assertions.sv
// Port checker for the xor unit.
`timescale 1ns/1ps
`default_nettype none
module xwf_chk (
    input wire logic        mclk,     // Clock.
    input wire logic        rst,      // Reset.
    input wire logic [15:0] instr,    // Word.
    input wire logic        mem_rd,   // Read.
    input wire logic [7:0]  wreg_q,   // W.
    input wire logic [4:0]  status_q, // Flags.
    input wire logic        done_q    // Done.
);
    logic [1:0] ph_q;
    wire        hit = ph_q == 2'h0 && instr[15:10] == 6'h06;
    wire        miss = ph_q == 2'h0 && !hit;
    always @(posedge mclk) ph_q <= rst ? 2'h0 : ph_q + 2'h1;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_rd_next: assert property (hit |=> mem_rd) else $error("no read");
    a_rd_phase: assert property (mem_rd |-> ph_q == 2'h1) else $error("read phase");
    a_rd_miss: assert property (miss |=> !mem_rd) else $error("read on miss");
    a_done_time: assert property (hit |-> ##4 done_q) else $error("done late");
    a_done_miss: assert property (miss |-> ##4 !done_q) else $error("done on miss");
    a_done_pulse: assert property (done_q |=> !done_q) else $error("done held");
    a_w_done: assert property ($changed(wreg_q) && !$past(rst) |-> done_q) else $error("stray W");
    a_w_flags: assert property (done_q && $changed(wreg_q) |-> status_q[4] == wreg_q[7] && status_q[2] == !wreg_q)
        else $error("flags");
endmodule // xwf_chk
bind xwf_core xwf_chk u_xwf_chk (.mclk(mclk), .rst(rst), .instr(instr), .mem_rd(mem_rd), .wreg_q(wreg_q),
    .status_q(status_q), .done_q(done_q));
`default_nettype wire

// file: tb/tb_xwf_core.sv
// Bench for the xor unit.
`timescale 1ns/1ps
`default_nettype none
module tb_xwf_core;
    logic        mclk = 1'h0, rst = 1'h1, ext_en = 1'h0, h, mem_rd, mem_we, done_q;
    logic [15:0] instr = 16'h0000;
    logic [11:0] mem_addr;
    logic [7:0]  mem_rdata = 8'h00, w = 8'h00, ew, mem_wdata, wreg_q;
    logic [4:0]  status_q;
    int          n_fail = 0, total_checks = 0;
    xwf_core u_xwf_core (.mclk(mclk), .rst(rst), .instr(instr), .ext_en(ext_en), .bsr_in(4'h5), .index_base(12'h100),
        .mem_rdata(mem_rdata), .status_in(5'h0B), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .wreg_q(wreg_q), .status_q(status_q), .done_q(done_q));
    initial forever #12.5 mclk = ~mclk;
    task chk(input logic [15:0] g, e);
        total_checks++;
        n_fail += g !== e;
        if (g !== e) $display("mismatch %0t %h %h", $time, g, e);
    endtask
    task print_verdict;
        $display("fails %0d of %0d", n_fail, total_checks);
        if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task op(input logic [15:0] i, input logic x, input logic [7:0] r, input logic [11:0] a);
        h = i[15:10] == 6'h06;
        ew = w ^ r;
        instr = i;
        ext_en = x;
        mem_rdata = r;
        @(posedge mclk) #1 chk({mem_rd, h ? mem_addr : 12'h000}, {h, a});
        // Inverted after the read edge so a late sample cannot pass.
        @(posedge mclk) #1 mem_rdata = ~r;
        repeat (2) @(posedge mclk);
        #1 chk({done_q, mem_we}, {h, h & i[9]});
        chk(mem_we ? mem_wdata : 8'h00, h & i[9] ? ew : 8'h00);
        if (h & !i[9]) w = ew;
        chk({wreg_q, status_q}, {w, h ? {ew[7], 1'h1, ew == 8'h00, 2'h3} : 5'h0B});
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        #1 rst = 1'h0;
        op(16'h185F, 1'h1, 8'hB5, 12'h15F);
        op(16'h1AAF, 1'h0, 8'hAF, 12'hFAF);
        op(16'h1B22, 1'h1, 8'hB5, 12'h522);
        op(16'h1860, 1'h1, 8'hB5, 12'hF60);
        op(16'h1C10, 1'h0, 8'h77, 12'h000);
        print_verdict;
    end
    initial begin
        #2000 n_fail++;
        print_verdict;
    end
endmodule // tb_xwf_core
`default_nettype wire
